// ---- core/rofmt_pkg.sv ----
/*
 * Constants and types of the reading output formatter: register map, field
 * positions, values after reset, format codes and the carriers.
 * Assumes nothing of its surroundings; every user names items as rofmt_pkg::name.
 */
package rofmt_pkg;

    // ----------------------------------------------------------------
    // Register map and fields.
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_FORMAT = 8'h00;
    localparam logic [7:0] REG_ELEMENTS = 8'h04;
    localparam logic [7:0] REG_BYTE_ORDER = 8'h08;
    localparam logic [7:0] REG_CONTROL = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam int FMT_TYPE_LSB = 0;
    localparam int FMT_LEN_LSB = 8;
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_PRESET_BIT = 1;

    // Format type codes written by software and length arguments.
    localparam logic [2:0] CMD_ASC = 3'h0;
    localparam logic [2:0] CMD_REAL = 3'h1;
    localparam logic [2:0] CMD_SRE = 3'h2;
    localparam logic [2:0] CMD_DRE = 3'h3;
    localparam logic [7:0] LEN_NONE = 8'h00;
    localparam logic [7:0] LEN_32 = 8'h20;
    localparam logic [7:0] LEN_64 = 8'h40;

    // Active format, as reported back to the host.
    typedef enum logic [2:0] {
        FMT_ASC = 3'h0,
        FMT_REAL32 = 3'h1,
        FMT_REAL64 = 3'h2,
        FMT_SRE = 3'h3,
        FMT_DRE = 3'h4
    } rofmt_fmt_t;

    // ----------------------------------------------------------------
    // Elements, reset values and stream constants.
    // ----------------------------------------------------------------
    localparam logic [2:0] EL_READING = 3'h0;
    localparam logic [2:0] EL_CHANNEL = 3'h1;
    localparam logic [2:0] EL_INDEX = 3'h2;
    localparam logic [2:0] EL_UNITS = 3'h3;
    localparam logic [2:0] EL_TIME = 3'h4;
    localparam logic [2:0] EL_STATUS = 3'h5;
    localparam logic [2:0] EL_NONE = 3'h7;
    localparam logic [5:0] ELEMS_ALL = 6'h3f;
    localparam logic [5:0] ELEMS_RESET = 6'h01;
    localparam logic [5:0] ELEMS_BINARY = 6'h17;
    localparam logic SWAP_RESET = 1'b1;
    localparam logic [7:0] HDR_BYTE0 = 8'h23;
    localparam logic [7:0] HDR_BYTE1 = 8'h30;
    localparam logic [7:0] SEP_CHAR = 8'h2c;
    localparam logic [7:0] HEX_DIGIT_BASE = 8'h30;
    localparam logic [7:0] HEX_ALPHA_BASE = 8'h57;
    localparam logic [4:0] BYTES_SINGLE = 5'h04;
    localparam logic [4:0] BYTES_DOUBLE = 5'h08;
    localparam logic [4:0] CHARS_NUMBER = 5'h10;
    localparam logic [4:0] CHARS_LETTER = 5'h01;
    localparam int FIFO_DEPTH = 32;
    localparam int BYTE_W = 8;

    // Formatter states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_HDR0 = 4'h2,
        ST_HDR1 = 4'h4,
        ST_ELEM = 4'h8
    } rofmt_state_t;

    // One conversion: both precisions of each element plus the text letters.
    typedef struct packed {
        logic from_buffer;
        logic [5:0][63:0] dbl;
        logic [5:0][31:0] sgl;
        logic [7:0] unit_char;
        logic [7:0] status_char;
    } rofmt_conv_t;

    // One byte of the output stream.
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } rofmt_byte_t;

endpackage

// ---- core/rofmt_formatter.sv ----
/*
 * Reading output formatter: register port, element sequencer and output FIFO.
 * Assumes a single clock, saved setup inputs stable on that clock, and a host
 * that drains the byte stream with valid and ready.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module rofmt_fifo #(
    parameter int WIDTH = rofmt_pkg::BYTE_W + 1,
    parameter int DEPTH = rofmt_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Filling side.
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Draining side.
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out,
    output logic [$clog2(DEPTH):0] count_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } rofmt_fifo_t;
    rofmt_fifo_t q;
    rofmt_fifo_t next_q;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready_out = q.count != (AW+1)'(DEPTH);
    assign out_valid_out = q.count != '0;
    assign out_data_out = q.mem[q.rptr];
    assign count_out = q.count;
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Pointer and storage update.
    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wptr] = in_data_in;
            next_q.wptr = q.wptr + 1'b1;
        end
        if (pop) begin
            next_q.rptr = q.rptr + 1'b1;
        end
        next_q.count = q.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // State register.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

module rofmt_formatter (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Saved power-on setup.
    input wire logic [2:0] saved_format_in,
    input wire logic [5:0] saved_elements_in,
    input wire logic saved_swap_in,
    // Conversions in.
    input wire logic conv_valid_in,
    output logic conv_ready_out,
    input wire rofmt_pkg::rofmt_conv_t conv_in,
    // Byte stream out.
    output logic byte_valid_out,
    input wire logic byte_ready_in,
    output logic [7:0] byte_data_out,
    output logic byte_last_out
);
    typedef struct packed {
        rofmt_pkg::rofmt_fmt_t fmt;
        logic swap;
        logic [5:0] elems;
        logic restore;
        rofmt_pkg::rofmt_state_t st;
        rofmt_pkg::rofmt_conv_t conv;
        logic bin;
        logic dbl;
        logic sw;
        logic [5:0] mask;
        logic [2:0] el;
        logic [4:0] bi;
        logic sep;
        logic [31:0] rdata;
    } rofmt_core_t;
    rofmt_core_t q;
    rofmt_core_t next_q;
    rofmt_pkg::rofmt_byte_t push_byte;
    rofmt_pkg::rofmt_byte_t pop_byte;
    logic push_valid;
    logic push_ready;
    logic push_ok;
    logic start;
    logic start_bin;
    logic [2:0] nxt_el;
    logic [4:0] el_bytes;
    logic [5:0] sh;
    logic [3:0] nib;
    logic [5:0] fifo_count;
    logic [2:0] wtype;
    logic [7:0] wlen;

    // Lowest selected element in a mask, or none.
    function automatic logic [2:0] lowest(input logic [5:0] m);
        logic [2:0] r;
        r = rofmt_pkg::EL_NONE;
        for (int i = 5; i >= 0; i--) begin
            if (m[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Byte selection for the current position in the string.
    // ----------------------------------------------------------------
    assign wtype = reg_wdata_in[rofmt_pkg::FMT_TYPE_LSB +: 3];
    assign wlen = reg_wdata_in[rofmt_pkg::FMT_LEN_LSB +: 8];
    assign start = conv_valid_in && conv_ready_out;
    assign start_bin = conv_in.from_buffer && q.fmt != rofmt_pkg::FMT_ASC;
    assign conv_ready_out = q.st == rofmt_pkg::ST_IDLE && !q.restore;
    assign nxt_el = lowest(q.mask & (6'h3e << q.el));
    assign push_ok = push_valid && push_ready;

    always_comb begin
        el_bytes = q.dbl ? rofmt_pkg::BYTES_DOUBLE : rofmt_pkg::BYTES_SINGLE;
        if (!q.bin) begin
            el_bytes = (q.el == rofmt_pkg::EL_UNITS || q.el == rofmt_pkg::EL_STATUS)
                ? rofmt_pkg::CHARS_LETTER : rofmt_pkg::CHARS_NUMBER;
        end
        push_valid = q.st != rofmt_pkg::ST_IDLE;
        push_byte.last = 1'b0;
        sh = '0;
        nib = 4'(q.conv.dbl[q.el] >> {4'(4'hf - q.bi[3:0]), 2'b00});
        push_byte.data = (nib < 4'ha) ? rofmt_pkg::HEX_DIGIT_BASE + 8'(nib)
            : rofmt_pkg::HEX_ALPHA_BASE + 8'(nib);
        unique case (q.st)
            rofmt_pkg::ST_HDR0: begin
                push_byte.data = rofmt_pkg::HDR_BYTE0;
            end
            rofmt_pkg::ST_HDR1: begin
                push_byte.data = rofmt_pkg::HDR_BYTE1;
                push_byte.last = q.mask == '0;
            end
            rofmt_pkg::ST_ELEM: begin
                push_byte.last = !q.sep && q.bi == el_bytes - 5'h01 && nxt_el == rofmt_pkg::EL_NONE;
                if (q.sep) begin
                    push_byte.data = rofmt_pkg::SEP_CHAR;
                end else if (q.bin && q.dbl) begin
                    sh = {q.sw ? q.bi[2:0] : 3'(3'h7 - q.bi[2:0]), 3'b000};
                    push_byte.data = 8'(q.conv.dbl[q.el] >> sh);
                end else if (q.bin) begin
                    sh = {1'b0, q.sw ? q.bi[1:0] : 2'(2'h3 - q.bi[1:0]), 3'b000};
                    push_byte.data = 8'(q.conv.sgl[q.el] >> sh);
                end else if (q.el == rofmt_pkg::EL_UNITS) begin
                    push_byte.data = q.conv.unit_char;
                end else if (q.el == rofmt_pkg::EL_STATUS) begin
                    push_byte.data = q.conv.status_char;
                end
            end
            default: begin
                push_byte.data = '0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Settings, register access and sequencer.
    // ----------------------------------------------------------------
    always_comb begin
        next_q = q;
        next_q.rdata = '0;
        if (q.restore) begin
            next_q.restore = 1'b0;
            next_q.fmt = (saved_format_in > 3'h4) ? rofmt_pkg::FMT_ASC : rofmt_pkg::rofmt_fmt_t'(saved_format_in);
            next_q.elems = saved_elements_in;
            next_q.swap = saved_swap_in;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                rofmt_pkg::REG_FORMAT: begin
                    unique case (wtype)
                        rofmt_pkg::CMD_ASC: next_q.fmt = rofmt_pkg::FMT_ASC;
                        rofmt_pkg::CMD_SRE: next_q.fmt = rofmt_pkg::FMT_SRE;
                        rofmt_pkg::CMD_DRE: next_q.fmt = rofmt_pkg::FMT_DRE;
                        rofmt_pkg::CMD_REAL: begin
                            if (wlen == rofmt_pkg::LEN_64) begin
                                next_q.fmt = rofmt_pkg::FMT_REAL64;
                            end else if (wlen == rofmt_pkg::LEN_32 || wlen == rofmt_pkg::LEN_NONE) begin
                                next_q.fmt = rofmt_pkg::FMT_REAL32;
                            end
                        end
                        default: next_q.fmt = q.fmt;
                    endcase
                end
                rofmt_pkg::REG_ELEMENTS: next_q.elems = reg_wdata_in[5:0];
                rofmt_pkg::REG_BYTE_ORDER: next_q.swap = reg_wdata_in[0];
                rofmt_pkg::REG_CONTROL: begin
                    if (reg_wdata_in[rofmt_pkg::CTRL_RESET_BIT] || reg_wdata_in[rofmt_pkg::CTRL_PRESET_BIT]) begin
                        next_q.fmt = rofmt_pkg::FMT_ASC;
                        next_q.swap = rofmt_pkg::SWAP_RESET;
                        next_q.elems = reg_wdata_in[rofmt_pkg::CTRL_PRESET_BIT]
                            ? rofmt_pkg::ELEMS_ALL : rofmt_pkg::ELEMS_RESET;
                    end
                end
                default: next_q.fmt = q.fmt;
            endcase
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                rofmt_pkg::REG_FORMAT: next_q.rdata = 32'(q.fmt);
                rofmt_pkg::REG_ELEMENTS: next_q.rdata = 32'(q.elems);
                rofmt_pkg::REG_BYTE_ORDER: next_q.rdata = 32'(q.swap);
                rofmt_pkg::REG_STATUS: next_q.rdata = {q.st != rofmt_pkg::ST_IDLE, 23'h000000, 2'h0, fifo_count};
                default: next_q.rdata = '0;
            endcase
        end
        unique case (q.st)
            rofmt_pkg::ST_IDLE: begin
                if (start) begin
                    next_q.conv = conv_in;
                    next_q.bin = start_bin;
                    next_q.dbl = q.fmt == rofmt_pkg::FMT_REAL64 || q.fmt == rofmt_pkg::FMT_DRE;
                    next_q.sw = q.swap && start_bin;
                    next_q.mask = q.elems & (start_bin ? rofmt_pkg::ELEMS_BINARY : rofmt_pkg::ELEMS_ALL);
                    next_q.el = lowest(next_q.mask);
                    next_q.bi = '0;
                    next_q.sep = 1'b0;
                    if (start_bin) begin
                        next_q.st = rofmt_pkg::ST_HDR0;
                    end else if (next_q.mask != '0) begin
                        next_q.st = rofmt_pkg::ST_ELEM;
                    end
                end
            end
            rofmt_pkg::ST_HDR0: begin
                if (push_ok) begin
                    next_q.st = rofmt_pkg::ST_HDR1;
                end
            end
            rofmt_pkg::ST_HDR1: begin
                if (push_ok) begin
                    next_q.st = (q.mask == '0) ? rofmt_pkg::ST_IDLE : rofmt_pkg::ST_ELEM;
                end
            end
            rofmt_pkg::ST_ELEM: begin
                if (push_ok) begin
                    if (q.sep) begin
                        next_q.sep = 1'b0;
                    end else if (q.bi == el_bytes - 5'h01) begin
                        next_q.bi = '0;
                        next_q.el = nxt_el;
                        next_q.sep = !q.bin;
                        if (nxt_el == rofmt_pkg::EL_NONE) begin
                            next_q.st = rofmt_pkg::ST_IDLE;
                        end
                    end else begin
                        next_q.bi = q.bi + 5'h01;
                    end
                end
            end
        endcase
    end

    // State register; power-up takes the saved setup one cycle after release.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            q <= '0;
            q.st <= rofmt_pkg::ST_IDLE;
            q.restore <= 1'b1;
            q.swap <= rofmt_pkg::SWAP_RESET;
            q.elems <= rofmt_pkg::ELEMS_ALL;
        end else begin
            q <= next_q;
        end
    end

    // Output FIFO; its ready stalls the sequencer.
    rofmt_fifo #(.WIDTH(rofmt_pkg::BYTE_W + 1), .DEPTH(rofmt_pkg::FIFO_DEPTH)) u_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(push_byte),
        .out_valid_out(byte_valid_out),
        .out_ready_in(byte_ready_in),
        .out_data_out(pop_byte),
        .count_out(fifo_count)
    );
    assign byte_data_out = pop_byte.data;
    assign byte_last_out = pop_byte.last;
    assign reg_rdata_out = q.rdata;

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    sequence hdr0_sent_s;
        push_ok && q.st == rofmt_pkg::ST_HDR0;
    endsequence
    sequence hdr1_sent_s;
        push_ok && q.st == rofmt_pkg::ST_HDR1;
    endsequence

    hdr_first_a: assert property (hdr0_sent_s |-> push_byte.data == rofmt_pkg::HDR_BYTE0 ##1 q.st == rofmt_pkg::ST_HDR1)
        else $error("Header does not open with the hash byte.");
    hdr_once_a: assert property (hdr1_sent_s |-> push_byte.data == rofmt_pkg::HDR_BYTE1 ##1 (q.st == rofmt_pkg::ST_ELEM || q.st == rofmt_pkg::ST_IDLE))
        else $error("Header second byte wrong or header repeated.");
    text_nohdr_a: assert property (start && !start_bin |=> q.st != rofmt_pkg::ST_HDR0 && !q.bin)
        else $error("Text conversion produced a header.");
    sense_text_a: assert property (start && !conv_in.from_buffer |=> !q.bin && !q.sw)
        else $error("Non-buffer reading sent in binary.");
    bin_units_a: assert property (q.st == rofmt_pkg::ST_ELEM && q.bin |-> q.el != rofmt_pkg::EL_UNITS && q.el != rofmt_pkg::EL_STATUS)
        else $error("Units or status element in binary string.");
    elem_order_a: assert property (q.st == rofmt_pkg::ST_ELEM && $past(q.st) == rofmt_pkg::ST_ELEM |-> q.el >= $past(q.el))
        else $error("Element order went backwards.");
    single_len_a: assert property (q.st == rofmt_pkg::ST_ELEM && q.bin && !q.dbl |-> q.bi < rofmt_pkg::BYTES_SINGLE)
        else $error("Single precision element longer than four bytes.");
    swap_byte_a: assert property (push_ok && q.st == rofmt_pkg::ST_ELEM && q.sw && !q.dbl && q.bi == 5'h00 |-> push_byte.data == q.conv.sgl[q.el][7:0])
        else $error("Swapped order does not start with the low byte.");
    sign_first_a: assert property (push_ok && q.st == rofmt_pkg::ST_ELEM && q.bin && !q.sw && q.dbl && q.bi == 5'h00 |-> push_byte.data == q.conv.dbl[q.el][63:56])
        else $error("Normal order does not start with the sign byte.");
    generic_len_a: assert property (reg_wr_in && !q.restore && reg_addr_in == rofmt_pkg::REG_FORMAT && wtype == rofmt_pkg::CMD_REAL && wlen == rofmt_pkg::LEN_NONE |=> q.fmt == rofmt_pkg::FMT_REAL32)
        else $error("Generic real without length is not single.");
    soft_reset_a: assert property (reg_wr_in && !q.restore && reg_addr_in == rofmt_pkg::REG_CONTROL && reg_wdata_in[rofmt_pkg::CTRL_RESET_BIT] |=> q.fmt == rofmt_pkg::FMT_ASC && q.swap)
        else $error("Reset command did not select text and swapped.");
    fmt_query_a: assert property (reg_rd_in && reg_addr_in == rofmt_pkg::REG_FORMAT |=> reg_rdata_out == 32'($past(q.fmt)))
        else $error("Format query returned the wrong code.");
endmodule

`default_nettype wire

// ---- tb/rofmt_host.sv ----
/*
 * Host model that drains the formatter's byte stream.
 * Assumes the bench clock and reset; stall_in holds the host off completely.
 */
`timescale 1ns/1ps
`default_nettype none
module rofmt_host (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Stream side.
    input wire logic stall_in,
    output logic byte_ready_out
);
    // ------------------------------------------------------------
    // Ready pattern
    // ------------------------------------------------------------
    // Accepts at random, so bytes are taken promptly and slowly.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            byte_ready_out <= 1'b0;
        end else begin
            byte_ready_out <= !stall_in && ($urandom_range(3) != 0);
        end
    end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 * Self-checking bench of the reading output formatter.
 * Assumes the formatter, its package and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic conv_valid_in = 1'b0;
    logic stall = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic [31:0] reg_rdata_out;
    logic conv_ready_out;
    logic byte_valid_out;
    logic byte_ready_in;
    logic byte_last_out;
    logic [7:0] byte_data_out;
    rofmt_pkg::rofmt_conv_t conv_in = '0;
    rofmt_pkg::rofmt_byte_t bq[$];
    logic [31:0] rq[$];
    int n_errors = 0;
    int checks_done = 0;
    // Conversion table: type, length, swap, element mask, buffer readout.
    logic [2:0] ct[8] = '{3'h2, 3'h2, 3'h3, 3'h1, 3'h0, 3'h2, 3'h2, 3'h1};
    logic [7:0] cl[8] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    logic cs[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [5:0] cm[8] = '{6'h3f, 6'h05, 6'h3f, 6'h12, 6'h3f, 6'h2b, 6'h00, 6'h01};
    logic cf[8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

    rofmt_formatter rofmt_formatter_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .saved_format_in(3'h3),
        .saved_elements_in(6'h15), .saved_swap_in(1'b0), .conv_valid_in(conv_valid_in),
        .conv_ready_out(conv_ready_out), .conv_in(conv_in), .byte_valid_out(byte_valid_out),
        .byte_ready_in(byte_ready_in), .byte_data_out(byte_data_out), .byte_last_out(byte_last_out));
    rofmt_host rofmt_host_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .stall_in(stall),
        .byte_ready_out(byte_ready_in));

    // ------------------------------------------------------------
    // Clock, compares and closing report
    // ------------------------------------------------------------
    // Free-running 50 ns clock.
    initial begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t register read %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_byte(input rofmt_pkg::rofmt_byte_t g, input rofmt_pkg::rofmt_byte_t e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t stream byte %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic timed_out();
        n_errors++;
        $display("BAD %0t wait ran out", $time);
        test_done();
    endtask
    // Watches read data and the byte stream, oldest note first.
    always @(posedge clk_sys_in) begin
        if (rd_seen) begin
            cmp_val(reg_rdata_out, rq.pop_front());
        end
        rd_seen <= reg_rd_in;
        if (byte_valid_out && byte_ready_in) begin
            cmp_byte({byte_data_out, byte_last_out}, (bq.size() > 0) ? bq.pop_front() : 'x);
        end
    end

    // ------------------------------------------------------------
    // Register and conversion drivers
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        rq.push_back(e);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? rofmt_pkg::HEX_DIGIT_BASE + {4'h0, n} : rofmt_pkg::HEX_ALPHA_BASE + {4'h0, n};
    endfunction
    // Notes the bytes one conversion must give; md 0 text, 1 single, 2 double.
    task automatic exp_conv(input int md, input logic sw, input logic [5:0] m, input rofmt_pkg::rofmt_conv_t c);
        int nb;
        logic [63:0] w;
        nb = (md == 2) ? 8 : 4;
        if (md != 0) begin
            bq.push_back({rofmt_pkg::HDR_BYTE0, 1'b0});
            bq.push_back({rofmt_pkg::HDR_BYTE1, 1'b0});
        end
        for (int e = 0; e < 6; e++) begin
            w = (md == 2) ? c.dbl[e] : {32'h0, c.sgl[e]};
            if (m[e] && md == 0) begin
                if (bq.size() > 0) begin
                    bq.push_back({rofmt_pkg::SEP_CHAR, 1'b0});
                end
                if (e == 3 || e == 5) begin
                    bq.push_back({(e == 3) ? c.unit_char : c.status_char, 1'b0});
                end else begin
                    for (int k = 15; k >= 0; k--) bq.push_back({hexc(c.dbl[e][k*4 +: 4]), 1'b0});
                end
            end else if (m[e] && e != 3 && e != 5) begin
                for (int k = 0; k < nb; k++) bq.push_back({w[(sw ? k : nb - 1 - k)*8 +: 8], 1'b0});
            end
        end
        if (bq.size() > 0) begin
            bq[bq.size() - 1].last = 1'b1;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int md;
        rofmt_pkg::rofmt_conv_t c;
        void'($urandom(32'h88361c01));
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        rd(rofmt_pkg::REG_FORMAT, 32'h3);
        rd(rofmt_pkg::REG_BYTE_ORDER, 32'h0);
        rd(rofmt_pkg::REG_ELEMENTS, 32'h15);
        wr(rofmt_pkg::REG_CONTROL, 32'h1);
        rd(rofmt_pkg::REG_FORMAT, 32'h0);
        rd(rofmt_pkg::REG_BYTE_ORDER, 32'h1);
        rd(rofmt_pkg::REG_ELEMENTS, 32'h1);
        wr(rofmt_pkg::REG_CONTROL, 32'h2);
        rd(rofmt_pkg::REG_ELEMENTS, 32'h3f);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h0);
        // Every format selection; the generic real without a length, with 32 and with 64.
        for (int i = 0; i < 6; i++) begin
            wr(rofmt_pkg::REG_FORMAT, {16'h0, 8'(i * 32 - 32) & {8{i > 1 && i < 4}}, 5'h0,
                3'((i == 0) ? 0 : (i < 4) ? 1 : i - 2)});
            rd(rofmt_pkg::REG_FORMAT, (i < 4) ? (i + 1) / 2 : i - 1);
        end
        wr(rofmt_pkg::REG_FORMAT, 32'h1001);
        rd(rofmt_pkg::REG_FORMAT, 32'h4);
        for (int i = 0; i < 8; i++) begin
            wr(rofmt_pkg::REG_FORMAT, {16'h0, cl[i], 5'h0, ct[i]});
            wr(rofmt_pkg::REG_ELEMENTS, {26'h0, cm[i]});
            wr(rofmt_pkg::REG_BYTE_ORDER, {31'h0, cs[i]});
            md = (ct[i] == 3'h0 || !cf[i]) ? 0 : (ct[i] == 3'h3 || cl[i] == 8'h40) ? 2 : 1;
            c.from_buffer = cf[i];
            c.unit_char = 8'($urandom);
            c.status_char = 8'($urandom);
            for (int e = 0; e < 6; e++) begin
                c.dbl[e] = {$urandom, $urandom};
                c.sgl[e] = $urandom;
            end
            exp_conv(md, cs[i] && md != 0, cm[i], c);
            stall <= (i == 2);
            conv_in <= c;
            conv_valid_in <= 1'b1;
            for (int t = 0; t <= 200; t++) begin
                @(posedge clk_sys_in);
                if (t == 200) timed_out();
                if (conv_ready_out) break;
            end
            conv_valid_in <= 1'b0;
            if (i == 2) begin
                repeat (60) @(posedge clk_sys_in);
                rd(rofmt_pkg::REG_STATUS, 32'h80000020);
                stall <= 1'b0;
            end
            for (int t = 0; t <= 2000; t++) begin
                @(posedge clk_sys_in);
                if (t == 2000) timed_out();
                if (bq.size() == 0 && conv_ready_out) break;
            end
        end
        repeat (5) @(posedge clk_sys_in);
        test_done();
    end
endmodule
`default_nettype wire
